//--- dv/tmr_core_bus_model.sv
module tmr_core_bus_model (
  output logic [16:0] core_addr,
  output logic [7:0] core_data,
  output logic core_write,
  output logic core_valid,
  input wire sys_clk
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {core_addr, core_data, core_write, core_valid} = '0;
  // one read cycle held for hold edges, then lines inverted on release
  task put(input [16:0] a, input [7:0] d, input int hold);
    @(posedge sys_clk);
    core_addr <= a;
    core_data <= d;
    core_valid <= 1'h1;
    repeat (hold) @(posedge sys_clk);
    core_valid <= 1'h0;
    core_addr <= ~a;
    core_data <= ~d;
  endtask
endmodule

//--- dv/tmr_trace_module_sva.sv
module tmr_trace_module_sva (
  input wire sys_clk,
  input wire resetn,
  input wire [5:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire core_valid,
  input wire comp_a_match
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // both write parts taken at one edge, and whether the target is read-only
  wire go = s_axi_awvalid & s_axi_awready & s_axi_wvalid & s_axi_wready;
  wire ro = s_axi_awaddr[5:2] inside {4'h6, 4'h7, 4'hB, 4'hE, 4'hF};
  property p_rlat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rlat: assert property (p_rlat) else $error("read answer late");
  property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_rhold: assert property (p_rhold) else $error("read data moved");
  property p_rfmt; s_axi_rvalid |-> s_axi_rresp == 2'h0 && s_axi_rdata[31:8] == 24'h0 && !s_axi_arready; endproperty
  a_rfmt: assert property (p_rfmt) else $error("read format wrong");
  property p_roerr; go && ro |=> s_axi_bvalid && s_axi_bresp == 2'h2; endproperty
  a_roerr: assert property (p_roerr) else $error("read-only write not refused");
  property p_rwok; go && !ro |=> s_axi_bvalid && s_axi_bresp == 2'h0; endproperty
  a_rwok: assert property (p_rwok) else $error("writable register refused");
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_bhold: assert property (p_bhold) else $error("write answer dropped");
  property p_bblk; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_bblk: assert property (p_bblk) else $error("write taken while answer pending");
  property p_acause; comp_a_match |-> $past(core_valid, 3); endproperty
  a_acause: assert property (p_acause) else $error("match without bus cycle");
endmodule
bind tmr_trace_module tmr_trace_module_sva tmr_trace_module_sva_inst (.*);

//--- dv/tmr_trace_module_tb_top.sv
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin error_cnt++; \
  $display("ERROR %s exp %0h got %0h", n, e, a); end end
module tmr_trace_module_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 0, resetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, capture_valid = 0, capture_paged = 0;
  logic [5:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [16:0] capture_word = '0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [16:0] core_addr;
  wire [7:0] core_data;
  wire core_write, core_valid, comp_a_match, comp_b_match, comp_c_match;
  int error_cnt = 0, tests_run = 0, cyc = 0, na = 0, nb = 0, nc = 0;
  // captured run: index and expected byte
  logic [11:0] cap[5] = '{12'h6A5, 12'h75B, 12'hB81, 12'hEE1, 12'hF01};
  // rows: index, response, written byte, byte read back
  logic [23:0] rows[14] = '{24'h00A5A5, 24'h103C3C, 24'h205A5A, 24'h30C3C3, 24'h401111, 24'h502222,
    24'h80FFE1, 24'h90FFE1, 24'hD0FFCF, 24'h62FF00, 24'h72FF00, 24'hB2FF00, 24'hE2FF00, 24'hF2FF00};
  logic [11:0] cfg[7] = '{12'h012, 12'h134, 12'h800, 12'h900, 12'hD00, 12'h2AB, 12'h3CD};
  logic [7:0] rv[3] = '{8'hFF, 8'hFE, 8'h00};
  tmr_trace_module tmr_trace_module_inst (.*);
  tmr_core_bus_model tmr_core_bus_model_inst (.*);
  initial forever #2 sys_clk = ~sys_clk;
  // match pulse counters and hang guard
  always @(posedge sys_clk) begin
    na <= na + comp_a_match;
    nb <= nb + comp_b_match;
    nc <= nc + comp_c_match;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      final_report();
    end
  end
  task final_report();
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task rst();
    @(posedge sys_clk);
    resetn <= 1'h0;
    repeat (20) @(posedge sys_clk);
    resetn <= 1'h1;
  endtask
  // write: both parts offered, each released when taken
  task wr(input [3:0] i, input [7:0] v, output [1:0] r);
    bit a, w;
    a = 0;
    w = 0;
    @(posedge sys_clk);
    s_axi_awaddr <= {i, 2'h0};
    s_axi_wdata <= {24'h0, v};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    while (!(a && w)) begin
      @(negedge sys_clk);
      a |= s_axi_awvalid && s_axi_awready;
      w |= s_axi_wvalid && s_axi_wready;
      @(posedge sys_clk);
      if (a) s_axi_awvalid <= 1'h0;
      if (w) s_axi_wvalid <= 1'h0;
    end
    do @(negedge sys_clk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    @(posedge sys_clk);
    s_axi_bready <= 1'h0;
  endtask
  task rd(input [3:0] i, output [31:0] d);
    @(posedge sys_clk);
    s_axi_araddr <= {i, 2'h0};
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do @(negedge sys_clk); while (!s_axi_arready);
    @(posedge sys_clk);
    s_axi_arvalid <= 1'h0;
    do @(negedge sys_clk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    @(posedge sys_clk);
    s_axi_rready <= 1'h0;
  endtask
  // one core cycle, then count the a and b match pulses that follow
  task hit(input [16:0] a, input [7:0] d, input int ea, input int eb);
    int a0, b0;
    a0 = na;
    b0 = nb;
    tmr_core_bus_model_inst.put(a, d, 1);
    repeat (8) @(posedge sys_clk);
    `CHK("match a", ea, na - a0)
    `CHK("match b", eb, nb - b0)
  endtask
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    int c0;
    rst();
    wr(4'hC, 8'h00, r);
    rst();
    foreach (rows[k]) begin
      wr(rows[k][23:20], rows[k][15:8], r);
      `CHK("bresp", rows[k][17:16], r)
      rd(rows[k][23:20], d);
      `CHK("rdata", {24'h0, rows[k][7:0]}, d)
    end
    foreach (cfg[k]) wr(cfg[k][11:8], cfg[k][7:0], r);
    hit(17'h01234, 8'h00, 1, 0);
    hit(17'h01235, 8'h00, 0, 0);
    hit(17'h0ABCD, 8'h00, 0, 1);
    wr(4'hD, 8'h05, r);
    hit(17'h01234, 8'hCD, 1, 1);
    hit(17'h0ABCD, 8'h00, 0, 0);
    // armed run: capture one word, gather flags, refuse a fifo write
    wr(4'hA, 8'h00, r);
    wr(4'hC, 8'hC0, r);
    @(posedge sys_clk);
    {capture_valid, capture_paged, capture_word} <= {2'h3, 17'h1A55B};
    @(posedge sys_clk);
    capture_valid <= 1'h0;
    hit(17'h01234, 8'hCD, 1, 1);
    c0 = nc;
    hit(17'h01122, 8'h00, 0, 0);
    `CHK("match c", 1, nc - c0)
    wr(4'h6, 8'h00, r);
    `CHK("ro bresp", 2'h2, r)
    foreach (cap[k]) begin
      rd(cap[k][11:8], d);
      `CHK("capture", {24'h0, cap[k][7:0]}, d)
    end
    wr(4'hC, 8'h80, r);
    rst();
    rd(4'h0, d);
    `CHK("kept", 32'h12, d)
    wr(4'hC, 8'h00, r);
    rst();
    foreach (rv[k]) begin
      rd(k[3:0], d);
      `CHK("reset", {24'h0, rv[k]}, d)
    end
    final_report();
  end
endmodule

//--- src/tmr_defs.vh
`ifndef TMR_DEFS_VH
`define TMR_DEFS_VH
// register indices (byte address = index * 4)
`define TMR_IDX_CAH 4'h0
`define TMR_IDX_CAL 4'h1
`define TMR_IDX_CBH 4'h2
`define TMR_IDX_CBL 4'h3
`define TMR_IDX_CCH 4'h4
`define TMR_IDX_CCL 4'h5
`define TMR_IDX_FH 4'h6
`define TMR_IDX_FL 4'h7
`define TMR_IDX_CAX 4'h8
`define TMR_IDX_CBX 4'h9
`define TMR_IDX_CCX 4'hA
`define TMR_IDX_FX 4'hB
`define TMR_IDX_CTL 4'hC
`define TMR_IDX_TRG 4'hD
`define TMR_IDX_STS 4'hE
`define TMR_IDX_CNT 4'hF
// power-on / non-end-run reset values
`define TMR_RST_CAH 8'hFF
`define TMR_RST_CAL 8'hFE
`define TMR_RST_ZERO 8'h00
`define TMR_RST_ADDR 17'h00000
// arm bit cleared when an end-trace run meets reset
`define TMR_ARM_CLR 8'hBF
// valid-word count limits
`define TMR_CNT_ZERO 4'h0
`define TMR_CNT_ONE 4'h1
`define TMR_CNT_FULL 4'h8
// writable masks of the mixed registers
`define TMR_MASK_CX 8'hE1
`define TMR_MASK_CTL 8'hF1
`define TMR_MASK_TRG 8'hCF
// field positions
`define TMR_CTL_ON 7
`define TMR_CTL_ARM 6
`define TMR_TRG_KIND 7
`define TMR_TRG_BEGIN 6
`define TMR_CX_DIR_ON 7
`define TMR_CX_DIR 6
`define TMR_CX_B16 0
// full mode trigger codes
`define TMR_TRG_AND_B 4'h5
`define TMR_TRG_ANDNOT_B 4'h6
// bus responses
`define TMR_RESP_OK 2'b00
`define TMR_RESP_SLVERR 2'b10
`endif

//--- src/tmr_trace_module.v
`include "tmr_defs.vh"
module tmr_trace_module (
  input wire sys_clk,
  input wire resetn,
  input wire [5:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [5:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [16:0] core_addr,
  input wire [7:0] core_data,
  input wire core_write,
  input wire core_valid,
  input wire capture_valid,
  input wire [16:0] capture_word,
  input wire capture_paged,
  output reg comp_a_match,
  output reg comp_b_match,
  output reg comp_c_match
);

  // per-bit compare: every stored bit must equal the bus bit
  function cmp_eq;
    input [7:0] stored;
    input [7:0] bus;
    begin
      cmp_eq = (stored == bus);
    end
  endfunction

  // direction and bit-16 qualifier from an extension register
  function ext_ok;
    input [7:0] ext;
    input b16;
    input wr;
    begin
      ext_ok = (ext[`TMR_CX_B16] == b16) &&
               (!ext[`TMR_CX_DIR_ON] || (ext[`TMR_CX_DIR] == wr));
    end
  endfunction

  reg [7:0] cah_r;
  reg [7:0] cal_r;
  reg [7:0] cbh_r;
  reg [7:0] cbl_r;
  reg [7:0] cch_r;
  reg [7:0] ccl_r;
  reg [7:0] cax_r;
  reg [7:0] cbx_r;
  reg [7:0] ccx_r;
  reg [7:0] ctl_r;
  reg [7:0] trg_r;
  reg [7:0] fh_r;
  reg [7:0] fl_r;
  reg [7:0] fx_r;
  reg af_r;
  reg bf_r;
  reg cf_r;
  reg [3:0] cnt_r;
  reg keep_r;
  reg aw_got_r;
  reg w_got_r;
  reg [3:0] aw_idx_r;
  reg [31:0] wd_r;
  reg [3:0] ws_r;
  reg [16:0] addr_s1_r;
  reg [16:0] addr_s2_r;
  reg [7:0] data_s1_r;
  reg [7:0] data_s2_r;
  reg wr_s1_r;
  reg wr_s2_r;
  reg vld_s1_r;
  reg vld_s2_r;

  wire full_mode = (trg_r[3:0] == `TMR_TRG_AND_B) || (trg_r[3:0] == `TMR_TRG_ANDNOT_B);
  wire armed = ctl_r[`TMR_CTL_ON] & ctl_r[`TMR_CTL_ARM];
  wire [7:0] sts = {af_r, bf_r, cf_r, 4'h0, armed};

  // write channel handshakes; a part taken before the other is latched, the write committed once both are in and strobe bit 0 is set
  assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
  assign s_axi_wready = !w_got_r && !s_axi_bvalid;
  wire aw_now = aw_got_r | (s_axi_awvalid & s_axi_awready);
  wire w_now = w_got_r | (s_axi_wvalid & s_axi_wready);
  wire [3:0] wr_idx = aw_got_r ? aw_idx_r : s_axi_awaddr[5:2];
  wire [31:0] wr_dat = w_got_r ? wd_r : s_axi_wdata;
  wire [3:0] wr_stb = w_got_r ? ws_r : s_axi_wstrb;
  wire do_wr = aw_now && w_now && !s_axi_bvalid && wr_stb[0];
  wire ro_idx = (wr_idx == `TMR_IDX_FH) || (wr_idx == `TMR_IDX_FL) ||
                (wr_idx == `TMR_IDX_FX) || (wr_idx == `TMR_IDX_STS) ||
                (wr_idx == `TMR_IDX_CNT);
  wire [7:0] wv = wr_dat[7:0];

  // software arming while idle starts a new run
  wire run_start = do_wr && (wr_idx == `TMR_IDX_CTL) &&
                   wv[`TMR_CTL_ARM] && wv[`TMR_CTL_ON] &&
                   !armed;

  // core address synchroniser, two stages
  always @(posedge sys_clk) begin
    if (!resetn) begin
      addr_s1_r <= `TMR_RST_ADDR;
      addr_s2_r <= `TMR_RST_ADDR;
    end else begin
      addr_s1_r <= core_addr;
      addr_s2_r <= addr_s1_r;
    end
  end

  // core data synchroniser, two stages
  always @(posedge sys_clk) begin
    if (!resetn) begin
      data_s1_r <= `TMR_RST_ZERO;
      data_s2_r <= `TMR_RST_ZERO;
    end else begin
      data_s1_r <= core_data;
      data_s2_r <= data_s1_r;
    end
  end

  // core direction synchroniser, two stages
  always @(posedge sys_clk) begin
    if (!resetn) begin
      wr_s1_r <= 1'b0;
      wr_s2_r <= 1'b0;
    end else begin
      wr_s1_r <= core_write;
      wr_s2_r <= wr_s1_r;
    end
  end

  // core cycle strobe synchroniser, two stages
  always @(posedge sys_clk) begin
    if (!resetn) begin
      vld_s1_r <= 1'b0;
      vld_s2_r <= 1'b0;
    end else begin
      vld_s1_r <= core_valid;
      vld_s2_r <= vld_s1_r;
    end
  end

  // comparator match logic
  wire a_hit = cmp_eq(cah_r, addr_s2_r[15:8]) && cmp_eq(cal_r, addr_s2_r[7:0]) &&
               ext_ok(cax_r, addr_s2_r[16], wr_s2_r);
  wire b_hit = full_mode ? (cmp_eq(cbl_r, data_s2_r) && ext_ok(cbx_r, cbx_r[`TMR_CX_B16], wr_s2_r)) :
               (cmp_eq(cbh_r, addr_s2_r[15:8]) && cmp_eq(cbl_r, addr_s2_r[7:0]) &&
                ext_ok(cbx_r, addr_s2_r[16], wr_s2_r));
  wire c_hit = cmp_eq(cch_r, addr_s2_r[15:8]) && cmp_eq(ccl_r, addr_s2_r[7:0]) &&
               ext_ok(ccx_r, addr_s2_r[16], wr_s2_r);

  // comparator a pulse from a flip-flop
  always @(posedge sys_clk) begin
    if (!resetn) begin
      comp_a_match <= 1'b0;
    end else begin
      comp_a_match <= vld_s2_r & a_hit;
    end
  end

  // comparator b pulse from a flip-flop
  always @(posedge sys_clk) begin
    if (!resetn) begin
      comp_b_match <= 1'b0;
    end else begin
      comp_b_match <= vld_s2_r & b_hit;
    end
  end

  // comparator c pulse from a flip-flop
  always @(posedge sys_clk) begin
    if (!resetn) begin
      comp_c_match <= 1'b0;
    end else begin
      comp_c_match <= vld_s2_r & c_hit;
    end
  end

  // end-trace run marker: set while enabled with begin cleared
  always @(posedge sys_clk) begin
    if (!resetn) begin
      keep_r <= keep_r;
    end else begin
      keep_r <= ctl_r[`TMR_CTL_ON] & !trg_r[`TMR_TRG_BEGIN];
    end
  end

  // software register file
  always @(posedge sys_clk) begin
    if (!resetn && !keep_r) begin
      cah_r <= `TMR_RST_CAH;
      cal_r <= `TMR_RST_CAL;
      cbh_r <= `TMR_RST_ZERO;
      cbl_r <= `TMR_RST_ZERO;
      cch_r <= `TMR_RST_ZERO;
      ccl_r <= `TMR_RST_ZERO;
      cax_r <= `TMR_RST_ZERO;
      cbx_r <= `TMR_RST_ZERO;
      ccx_r <= `TMR_RST_ZERO;
      ctl_r <= `TMR_RST_ZERO;
      trg_r <= `TMR_RST_ZERO;
    end else if (!resetn) begin
      ctl_r <= ctl_r & `TMR_ARM_CLR; // kept contents, run ends
    end else if (do_wr && !ro_idx) begin
      case (wr_idx)
        `TMR_IDX_CAH: cah_r <= wv;
        `TMR_IDX_CAL: cal_r <= wv;
        `TMR_IDX_CBH: cbh_r <= wv;
        `TMR_IDX_CBL: cbl_r <= wv;
        `TMR_IDX_CCH: cch_r <= wv;
        `TMR_IDX_CCL: ccl_r <= wv;
        `TMR_IDX_CAX: cax_r <= wv & `TMR_MASK_CX;
        `TMR_IDX_CBX: cbx_r <= wv & `TMR_MASK_CX;
        `TMR_IDX_CCX: ccx_r <= wv & `TMR_MASK_CX;
        `TMR_IDX_CTL: ctl_r <= wv & `TMR_MASK_CTL;
        `TMR_IDX_TRG: trg_r <= wv & `TMR_MASK_TRG;
        default: cah_r <= cah_r;
      endcase
    end
  end

  // capture side: fifo words, hit flags and count, hardware only
  always @(posedge sys_clk) begin
    if (!resetn && !keep_r) begin
      fh_r <= `TMR_RST_ZERO;
      fl_r <= `TMR_RST_ZERO;
      fx_r <= `TMR_RST_ZERO;
      af_r <= 1'b0;
      bf_r <= 1'b0;
      cf_r <= 1'b0;
      cnt_r <= `TMR_CNT_ZERO;
    end else if (resetn) begin
      if (run_start) begin
        af_r <= 1'b0; // new run clears flags and count
        bf_r <= 1'b0;
        cf_r <= 1'b0;
        cnt_r <= `TMR_CNT_ZERO;
      end else if (armed) begin
        af_r <= af_r | comp_a_match;
        bf_r <= bf_r | comp_b_match;
        cf_r <= cf_r | comp_c_match;
        if (capture_valid) begin
          fh_r <= capture_word[15:8];
          fl_r <= capture_word[7:0];
          fx_r <= {capture_paged, 6'h00, capture_word[16]};
          if (cnt_r != `TMR_CNT_FULL)
            cnt_r <= cnt_r + `TMR_CNT_ONE; // saturates at fifo depth
        end
      end
    end
  end

  // write side handshake and response
  always @(posedge sys_clk) begin
    if (!resetn) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      aw_idx_r <= 4'h0;
      wd_r <= 32'h00000000;
      ws_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `TMR_RESP_OK;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r <= 1'b1;
        aw_idx_r <= s_axi_awaddr[5:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r <= 1'b1;
        wd_r <= s_axi_wdata;
        ws_r <= s_axi_wstrb;
      end
      if (aw_now && w_now && !s_axi_bvalid) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= ro_idx ? `TMR_RESP_SLVERR : `TMR_RESP_OK;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read mux over the sixteen registers
  reg [7:0] rd_byte;
  always @* begin
    case (s_axi_araddr[5:2])
      `TMR_IDX_CAH: rd_byte = cah_r;
      `TMR_IDX_CAL: rd_byte = cal_r;
      `TMR_IDX_CBH: rd_byte = cbh_r;
      `TMR_IDX_CBL: rd_byte = cbl_r;
      `TMR_IDX_CCH: rd_byte = cch_r;
      `TMR_IDX_CCL: rd_byte = ccl_r;
      `TMR_IDX_FH: rd_byte = fh_r;
      `TMR_IDX_FL: rd_byte = fl_r;
      `TMR_IDX_CAX: rd_byte = cax_r;
      `TMR_IDX_CBX: rd_byte = cbx_r;
      `TMR_IDX_CCX: rd_byte = ccx_r;
      `TMR_IDX_FX: rd_byte = fx_r;
      `TMR_IDX_CTL: rd_byte = ctl_r;
      `TMR_IDX_TRG: rd_byte = trg_r;
      `TMR_IDX_STS: rd_byte = sts;
      `TMR_IDX_CNT: rd_byte = {4'h0, cnt_r};
      default: rd_byte = 8'h00;
    endcase
  end

  // read channel: answer one cycle after address taken
  assign s_axi_arready = !s_axi_rvalid;
  always @(posedge sys_clk) begin
    if (!resetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `TMR_RESP_OK;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, rd_byte};
      s_axi_rresp <= `TMR_RESP_OK;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule
